// >>> src/seq_pkg.sv
// What this block does
// - Each five-input control table drives eight outputs, all high while disabled.
// - Shared control lines are active-low wired-OR; any source pulls low.
// - Eight major states, each one or two processor periods, named by flags and phase.
// - Fetch: optional skip increment, then read instruction and increment program counter.
// - Effective-address state forms the operand address; direct jump ends here.
// - Indirect state reads the pointer; auto-index locations are written back next phase.
// - Memory-execute moves the operand; jump and call finish here without memory access.
// - Increment- and decrement-test take one more period to write the word back.
// - Non-memory execute; programmed transfers take one extra period.
// - Interrupt entry stores PC at 0, forces zero jump, address 1, then indirect.
// - A device channel request may enter the channel state on any processor pulse.
// - Console functions other than start, stop and reset enter the console key state.
// - Stop only sets halt pending; the halt happens at the next fetch.
// - Reset halts at once and forces the fetch state.
// - Memory power low sets halt pending and hard reset, like console reset.
// - Restart is accepted only once memory power is good again.
// - With auto-restart fitted, early power warning sets power-low, an interrupt request.
// - After both power inputs return high, wait 2 ms before restart action.
// - After the wait: key on does nothing; key locked jumps direct to 0.
// - Flag-test instruction issues a test strobe that samples done or busy.
// - Channel indicator held during channel state; bus hold in data-holding phases.
// - Apart from reset and restart, the major state and phase flip-flops change only at the end of a processor pulse.
// - Period 300 ns, 400 ns when stretched, doubled to 600 or 800 ns when extended.
// - A slow memory holding the sync line low freezes timing in the hold phase.
package seq_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CLEAR  = 8'h0C;
  localparam int CTRL_INT_EN   = 0;
  localparam int CTRL_AUTO_OPT = 1;
  localparam int CTRL_KEY_LOCK = 2;
  localparam int CMD_START     = 0;
  localparam int CMD_STOP      = 1;
  localparam int CMD_RESET     = 2;
  localparam int CMD_KEY       = 3;
  localparam int CLR_POWER_LOW = 0;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int PERIOD_BASE_NS = 300;
  localparam int PERIOD_SLOW_NS = 400;
  localparam int HOLD_NS        = 200;
  localparam int RESTART_NS     = 2000000;
  localparam logic [7:0] CYC_BASE = 8'((PERIOD_BASE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] CYC_SLOW = 8'((PERIOD_SLOW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] CYC_HOLD = 8'((HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam int RESTART_CYCLES_DEF = (RESTART_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // Major states, phases, instruction kinds
  // ----------------------------------------
  typedef enum logic [7:0] {
    ST_FETCH = 8'h01, ST_EFA = 8'h02, ST_DEFER = 8'h04, ST_EXM = 8'h08,
    ST_EXN = 8'h10, ST_PI = 8'h20, ST_DCH = 8'h40, ST_KEY = 8'h80
  } major_e;
  localparam logic [1:0] PH_0    = 2'h0;
  localparam logic [1:0] PH_1    = 2'h1;
  localparam logic [1:0] PH_SKIP = 2'h2;
  localparam logic [2:0] K_MEM = 3'h0, K_JUMP = 3'h1, K_CALL = 3'h2, K_INCT = 3'h3;
  localparam logic [2:0] K_DECT = 3'h4, K_IOXFER = 3'h5, K_IOTEST = 3'h6, K_ALU = 3'h7;

  // Control line positions (active low on CONTROL_N)
  localparam int C_MEM_READ = 0;
  localparam int C_MEM_WRITE = 1;
  localparam int C_PC_INC = 2;
  localparam int C_LOAD_IR = 3;
  localparam int C_LOAD_MA = 4;
  localparam int C_IO_DATA = 5;
  localparam int C_IO_TEST = 6;
  localparam int C_BUS_HOLD = 7;

endpackage : seq_pkg

// >>> src/cpu_major_state_sequencer.sv
`timescale 1ns/1ps
module cpu_major_state_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned RESTART_CYCLES = RESTART_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // Timing conditions
  input  wire logic        SYNC_LINE,
  input  wire logic        EXTEND,
  input  wire logic        SLOW_CHANNEL,
  // Instruction decode from datapath
  input  wire logic        MEMORY_REFERENCE_FLAG,
  input  wire logic        INDIRECT,
  input  wire logic        AUTO_INDEX,
  input  wire logic        SKIP_PENDING,
  input  wire logic [2:0]  INSTR_KIND,
  // Requests and device responses
  input  wire logic        INT_REQ,
  input  wire logic        DCH_REQ,
  input  wire logic        SELECTED_DONE,
  input  wire logic        SELECTED_BUSY,
  input  wire logic        TEST_SEL_BUSY,
  // Power monitor
  input  wire logic        MEM_OK,
  input  wire logic        EARLY_POWER_WARNING_N,
  // Sequencer outputs
  output logic             CPU_TICK,
  output logic [7:0]       MAJOR_STATE,
  output logic             PHASE_BIT_A,
  output logic             PHASE_BIT_B,
  output logic             RUNNING,
  output logic [7:0]       CONTROL_N,
  output logic             TEST_RESULT,
  output logic             DCH_ACTIVE,
  output logic             PC_LOAD_ZERO,
  // Open-drain shared lines
  output logic             BUS_HOLD_O,
  output logic             BUS_HOLD_OE,
  output logic             DEVICE_RESET_O,
  output logic             DEVICE_RESET_OE
);

  localparam int RW = $clog2(RESTART_CYCLES + 1);

  // ----------------------------------------
  // Control tables
  // ----------------------------------------
  // State table: address is {state code, phase}
  function automatic logic [7:0] rom_state(input logic en, input logic [4:0] a);
    logic [7:0] y;
    y = 8'hFF;
    if (en) begin
      unique case (a)
        5'h00:   y = 8'hF2;  // Fetch: read, load instruction, bump PC
        5'h02:   y = 8'hFB;  // Skip increment only
        5'h04:   y = 8'hEF;  // Address into MA
        5'h08:   y = 8'hEE;  // Pointer read into MA
        5'h09:   y = 8'hFD;  // Auto-index write back
        5'h14:   y = 8'hFD;  // PC stored at 0
        5'h15:   y = 8'hE7;  // Zero jump and MA load
        5'h18:   y = 8'h7E;  // Channel read, data held
        5'h19:   y = 8'h7D;  // Channel write, data held
        5'h1C:   y = 8'hF7;  // Console function code
        default: y = 8'hFF;
      endcase
    end
    return y;
  endfunction : rom_state

  // Instruction table: address is {kind, phase}
  function automatic logic [7:0] rom_instr(input logic en, input logic [4:0] a);
    logic [7:0] y;
    y = 8'hFF;
    if (en) begin
      unique case (a)
        5'h00, 5'h0C, 5'h10: y = 8'hFE;  // Operand read
        5'h0D, 5'h11:        y = 8'hFD;  // Test word write back
        5'h14, 5'h15:        y = 8'hDF;  // Data transfer strobe
        5'h18:               y = 8'hBF;  // Flag test strobe
        default:             y = 8'hFF;
      endcase
    end
    return y;
  endfunction : rom_instr

  function automatic logic [2:0] state_code(input major_e s);
    logic [2:0] c;
    c = 3'h0;
    unique case (s)
      ST_FETCH: c = 3'h0;
      ST_EFA:   c = 3'h1;
      ST_DEFER: c = 3'h2;
      ST_EXM:   c = 3'h3;
      ST_EXN:   c = 3'h4;
      ST_PI:    c = 3'h5;
      ST_DCH:   c = 3'h6;
      ST_KEY:   c = 3'h7;
      default:  c = 3'h0;
    endcase
    return c;
  endfunction : state_code

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  major_e      state, next_state, ret_state;
  logic [1:0]  phase, next_phase, ret_phase, fetch_ph;
  logic [7:0]  cyc, period;
  logic        tick, run, halt_pending, hard_reset_flag, power_low_flag, key_pending;
  logic        mem_ok_q, dev_reset, armed, restart_go, test_result;
  logic [RW-1:0] rcnt;
  logic [2:0]  ctrl;
  logic [7:0]  rom_a, rom_b, control_n;
  logic        wr, start_cmd, stop_cmd, reset_cmd, key_cmd, clr_pl, reset_now;
  logic        start_ok, is_exec, rmw, outx, slow, boundary, int_take, halt_take;
  logic        quiet;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Zero wait state; unmapped offsets answer with an error
  assign PREADY    = 1'b1;
  assign wr        = PSEL & PENABLE & PWRITE;
  assign start_cmd = wr & (PADDR == OFS_CMD) & PWDATA[CMD_START];
  assign stop_cmd  = wr & (PADDR == OFS_CMD) & PWDATA[CMD_STOP];
  assign reset_cmd = wr & (PADDR == OFS_CMD) & PWDATA[CMD_RESET];
  assign key_cmd   = wr & (PADDR == OFS_CMD) & PWDATA[CMD_KEY];
  assign clr_pl    = wr & (PADDR == OFS_CLEAR) & PWDATA[CLR_POWER_LOW];

  always_comb begin
    PRDATA  = 32'h0;
    PSLVERR = 1'b0;
    unique case (PADDR)
      OFS_CTRL:   PRDATA = {29'h0, ctrl};
      OFS_CMD:    PRDATA = 32'h0;
      OFS_STATUS: PRDATA = {18'h0, power_low_flag, hard_reset_flag, halt_pending, run, phase, state};
      OFS_CLEAR:  PRDATA = 32'h0;
      default:    PSLVERR = PSEL & PENABLE;
    endcase
  end

  // Control register
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ctrl <= CTRL_RESET;
    end else if (wr && PADDR == OFS_CTRL) begin
      ctrl <= PWDATA[2:0];
    end
  end

  // ----------------------------------------
  // Processor clock generator
  // ----------------------------------------
  assign rmw    = (state == ST_EXM) & (INSTR_KIND == K_INCT || INSTR_KIND == K_DECT);
  assign outx   = (state == ST_EXN) & (INSTR_KIND == K_IOXFER);
  assign slow   = (state == ST_DCH) & SLOW_CHANNEL;
  // Stretch adds one base step, extend doubles the whole period
  assign period = (rmw | outx | slow ? CYC_SLOW : CYC_BASE) << EXTEND;

  // Counter freezes in the hold phase while a slow memory holds sync low
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      cyc  <= 8'h00;
      tick <= 1'b0;
    end else if (cyc == CYC_HOLD && !SYNC_LINE) begin
      tick <= 1'b0;
    end else if (cyc >= period - 8'h01) begin
      cyc  <= 8'h00;
      tick <= 1'b1;
    end else begin
      cyc  <= cyc + 8'h01;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Next major state
  // ----------------------------------------
  assign fetch_ph = SKIP_PENDING ? PH_SKIP : PH_0;

  always_comb begin
    next_state = state;
    next_phase = PH_0;
    unique case (state)
      ST_FETCH: begin
        if (phase == PH_SKIP) begin
          next_phase = PH_0;
        end else begin
          next_state = MEMORY_REFERENCE_FLAG ? ST_EFA : ST_EXN;
        end
      end
      ST_EFA: begin
        if (INSTR_KIND == K_JUMP && !INDIRECT) begin
          next_state = ST_FETCH;
          next_phase = fetch_ph;
        end else begin
          next_state = INDIRECT ? ST_DEFER : ST_EXM;
        end
      end
      ST_DEFER: begin
        if (phase == PH_0 && AUTO_INDEX) begin
          next_phase = PH_1;
        end else begin
          next_state = INDIRECT ? ST_DEFER : ST_EXM;
        end
      end
      ST_EXM: begin
        if (phase == PH_0 && (INSTR_KIND == K_INCT || INSTR_KIND == K_DECT)) begin
          next_phase = PH_1;
        end else begin
          next_state = ST_FETCH;
          next_phase = fetch_ph;
        end
      end
      ST_EXN: begin
        if (phase == PH_0 && INSTR_KIND == K_IOXFER) begin
          next_phase = PH_1;
        end else begin
          next_state = ST_FETCH;
          next_phase = fetch_ph;
        end
      end
      ST_PI: begin
        if (phase == PH_0) begin
          next_phase = PH_1;
        end else begin
          next_state = ST_DEFER;
        end
      end
      ST_DCH: begin
        if (phase == PH_0) begin
          next_phase = PH_1;
        end else begin
          next_state = ret_state;
          next_phase = ret_phase;
        end
      end
      ST_KEY: begin
        next_state = ST_FETCH;
        next_phase = PH_0;
      end
      default: next_state = ST_FETCH;
    endcase
  end

  // Fetch boundary decisions
  assign quiet     = !reset_now & !restart_go;
  assign reset_now = reset_cmd | !MEM_OK;
  assign boundary  = tick & run & !DCH_REQ & (state != ST_FETCH) & (state != ST_DCH) &
                     (next_state == ST_FETCH);
  assign halt_take = boundary & halt_pending;
  assign int_take  = boundary & !halt_pending & ctrl[CTRL_INT_EN] & (INT_REQ | power_low_flag);

  // ----------------------------------------
  // Major state register
  // ----------------------------------------
  // Reset and restart are applied at once; every other change waits for the pulse
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state     <= ST_FETCH;
      phase     <= PH_0;
      ret_state <= ST_FETCH;
      ret_phase <= PH_0;
    end else if (reset_now || restart_go) begin
      state <= ST_FETCH;
      phase <= PH_0;
    end else if (tick) begin
      if (DCH_REQ && state != ST_DCH) begin
        ret_state <= (!run && state == ST_FETCH) ? state : next_state;
        ret_phase <= (!run && state == ST_FETCH) ? phase : next_phase;
        state     <= ST_DCH;
        phase     <= PH_0;
      end else if (!run && state == ST_FETCH) begin
        if (key_pending) begin
          state <= ST_KEY;
          phase <= PH_0;
        end
      end else if (int_take) begin
        state <= ST_PI;
        phase <= PH_0;
      end else begin
        state <= next_state;
        phase <= next_phase;
      end
    end
  end

  // ----------------------------------------
  // Run, halt and console flags
  // ----------------------------------------
  assign start_ok = start_cmd & MEM_OK & !run;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      run <= 1'b0;
    end else if (reset_now) begin
      run <= 1'b0;
    end else if (restart_go || start_ok) begin
      run <= 1'b1;
    end else if (halt_take) begin
      run <= 1'b0;
    end
  end

  // Set wins over clear on every flag
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      halt_pending    <= 1'b0;
      hard_reset_flag <= 1'b0;
      key_pending     <= 1'b0;
    end else begin
      if (stop_cmd || !MEM_OK) begin
        halt_pending <= 1'b1;
      end else if (halt_take || start_ok || restart_go) begin
        halt_pending <= 1'b0;
      end
      if (!MEM_OK) begin
        hard_reset_flag <= 1'b1;
      end else if (start_ok || restart_go) begin
        hard_reset_flag <= 1'b0;
      end
      if (key_cmd && !run && MEM_OK) begin
        key_pending <= 1'b1;
      end else if (state == ST_KEY || reset_now) begin
        key_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Power monitor and auto restart
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      power_low_flag <= 1'b0;
      mem_ok_q       <= 1'b1;
      dev_reset      <= 1'b0;
    end else begin
      mem_ok_q <= MEM_OK;
      // One pulse per console reset or per loss of memory power
      dev_reset <= reset_cmd | (mem_ok_q & !MEM_OK);
      if (ctrl[CTRL_AUTO_OPT] && !EARLY_POWER_WARNING_N) begin
        power_low_flag <= 1'b1;
      end else if (clr_pl) begin
        power_low_flag <= 1'b0;
      end
    end
  end

  // Delay restarts from zero if either input drops again
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      armed      <= 1'b0;
      rcnt       <= '0;
      restart_go <= 1'b0;
    end else begin
      restart_go <= 1'b0;
      if (!MEM_OK || (ctrl[CTRL_AUTO_OPT] && !EARLY_POWER_WARNING_N)) begin
        armed <= ctrl[CTRL_AUTO_OPT];
        rcnt  <= '0;
      end else if (armed) begin
        if (rcnt == RW'(RESTART_CYCLES - 1)) begin
          armed      <= 1'b0;
          rcnt       <= '0;
          restart_go <= ctrl[CTRL_KEY_LOCK];
        end else begin
          rcnt <= rcnt + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Control lines and device-facing outputs
  // ----------------------------------------
  assign is_exec = (state == ST_EXM) | (state == ST_EXN);
  assign rom_a   = rom_state(!is_exec && (run || state != ST_FETCH), {state_code(state), phase});
  assign rom_b   = rom_instr(is_exec, {INSTR_KIND, phase});

  // Two tables share the lines: any low output wins
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      control_n <= 8'hFF;
    end else begin
      control_n <= rom_a & rom_b;
    end
  end

  // Test strobe samples done or busy instead of moving data
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      test_result <= 1'b0;
    end else if (!control_n[C_IO_TEST]) begin
      test_result <= TEST_SEL_BUSY ? SELECTED_BUSY : SELECTED_DONE;
    end
  end

  assign CPU_TICK        = tick;
  assign MAJOR_STATE     = state;
  assign PHASE_BIT_A     = phase[0];
  assign PHASE_BIT_B     = phase[1];
  assign RUNNING         = run;
  assign CONTROL_N       = control_n;
  assign TEST_RESULT     = test_result;
  assign DCH_ACTIVE      = (state == ST_DCH);
  assign PC_LOAD_ZERO    = restart_go;
  assign BUS_HOLD_O      = 1'b0;
  assign BUS_HOLD_OE     = !control_n[C_BUS_HOLD];
  assign DEVICE_RESET_O  = 1'b0;
  assign DEVICE_RESET_OE = dev_reset;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  AST_ROM_IDLE_HIGH: assert property (is_exec |-> rom_a == 8'hFF)
    else $error("state table not high while disabled");
  AST_WIRED_LOW: assert property (!rom_b[C_IO_TEST] |=> !CONTROL_N[C_IO_TEST])
    else $error("shared line not pulled low");
  AST_PHASE_LEGAL: assert property (phase != 2'h3 && (phase != PH_SKIP || state == ST_FETCH))
    else $error("illegal phase");
  AST_SKIP_FIRST: assert property (tick && run && quiet && !DCH_REQ && state == ST_FETCH && phase == PH_SKIP
                                   |=> state == ST_FETCH && phase == PH_0)
    else $error("skip increment not followed by fetch read");
  AST_TEST_WRITEBACK: assert property (tick && quiet && !DCH_REQ && state == ST_EXM && phase == PH_0 &&
                                       INSTR_KIND == K_INCT |=> state == ST_EXM && phase == PH_1)
    else $error("test word missing write back period");
  AST_PI_TO_DEFER: assert property (tick && quiet && !DCH_REQ && state == ST_PI && phase == PH_1
                                    |=> state == ST_DEFER)
    else $error("interrupt entry not followed by indirect");
  AST_DCH_FIRST: assert property (tick && quiet && DCH_REQ && state != ST_DCH |=> DCH_ACTIVE)
    else $error("channel request not served first");
  AST_RESET_HALT: assert property (reset_cmd |=> state == ST_FETCH && !RUNNING && phase == PH_0)
    else $error("reset did not halt into fetch");
  AST_POWER_FLAGS: assert property (!MEM_OK |=> halt_pending && hard_reset_flag && !RUNNING)
    else $error("power loss flags not set");
  AST_RESET_PULSE: assert property (reset_cmd || (mem_ok_q && !MEM_OK) |=> DEVICE_RESET_OE && !DEVICE_RESET_O)
    else $error("device reset pulse missing");
  AST_TICK_SPACING: assert property (tick |=> !tick [*8])
    else $error("processor pulses too close");
  AST_SYNC_FREEZE: assert property (cyc == CYC_HOLD && !SYNC_LINE |=> cyc == CYC_HOLD && !tick)
    else $error("timing not frozen by sync line");

  COV_INT_ENTRY: cover property (tick && int_take ##1 state == ST_PI);
  COV_DCH: cover property (state == ST_DCH && phase == PH_1);
  COV_RESTART: cover property (restart_go);
  COV_KEY: cover property (state == ST_KEY);

endmodule : cpu_major_state_sequencer

// >>> tb/mem_io_model.sv
`timescale 1ns/1ps
module mem_io_model
  import seq_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Sequencer side
  input  wire logic [7:0] control_n,
  input  wire logic       slow,
  output logic            sync_line,
  output logic            selected_done,
  output logic            selected_busy
);
  logic [3:0] hold;
  // Slow memory stalls each read; one high cycle lets timing creep on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hold <= 4'h0;
    else if (slow && !control_n[C_MEM_READ] && hold == 4'h0) hold <= 4'hC;
    else if (hold != 4'h0) hold <= hold - 4'h1;
  end
  assign sync_line     = (hold == 4'h0);
  // Device always reports done, never busy
  assign selected_done = 1'b1;
  assign selected_busy = 1'b0;
endmodule : mem_io_model

// >>> tb/cpu_major_state_sequencer_tb.sv
`timescale 1ns/1ps
module cpu_major_state_sequencer_tb;
  import seq_pkg::*;
  // ----------------------------------------
  // Signals, clock, instances
  // ----------------------------------------
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, sync, slow = 0;
  logic [7:0] paddr = 8'h00, mstate, ctl_n;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, tick, pha, phb, running, tres, dch_active, pcz, bh, bhe, dr, dre;
  logic mref = 0, int_req = 0, dch_req = 0, sel_busy = 0, mem_ok = 1, early_n = 1, sdone, sbusy, skip = 0;
  logic [2:0] kind = K_IOTEST;
  int num_errors = 0, cmp_count = 0, n;
  localparam int RST_CYC = 20;  // Short restart delay keeps the run brief
  always #2 clk = ~clk;
  cpu_major_state_sequencer #(.RESTART_CYCLES(RST_CYC)) i_cpu_major_state_sequencer (
    .CLK_SYS(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .SYNC_LINE(sync), .EXTEND(1'b0), .SLOW_CHANNEL(1'b0), .MEMORY_REFERENCE_FLAG(mref),
    .INDIRECT(1'b0), .AUTO_INDEX(1'b0), .SKIP_PENDING(skip), .INSTR_KIND(kind),
    .INT_REQ(int_req), .DCH_REQ(dch_req), .SELECTED_DONE(sdone), .SELECTED_BUSY(sbusy),
    .TEST_SEL_BUSY(sel_busy), .MEM_OK(mem_ok), .EARLY_POWER_WARNING_N(early_n),
    .CPU_TICK(tick), .MAJOR_STATE(mstate), .PHASE_BIT_A(pha), .PHASE_BIT_B(phb),
    .RUNNING(running), .CONTROL_N(ctl_n), .TEST_RESULT(tres), .DCH_ACTIVE(dch_active),
    .PC_LOAD_ZERO(pcz), .BUS_HOLD_O(bh), .BUS_HOLD_OE(bhe), .DEVICE_RESET_O(dr),
    .DEVICE_RESET_OE(dre));
  mem_io_model i_mem_io_model (.clk(clk), .resetn(resetn), .control_n(ctl_n), .slow(slow),
    .sync_line(sync), .selected_done(sdone), .selected_busy(sbusy));
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Master holds the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin num_errors++; wrap_up(); end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  function automatic logic cond(input int s);
    case (s)
      0: cond = (tick === 1'b1);
      1: cond = (running === 1'b0);
      2: cond = (dch_active === 1'b1);
      3: cond = (pcz === 1'b1);
      4: cond = (dre === 1'b1);
      6: cond = (mstate === ST_EXM && pha === 1'b1);
      7: cond = (mstate === ST_PI);
      8: cond = (mstate === ST_DEFER);
      9: cond = (mstate === ST_KEY);
      default: cond = (mstate === ST_EXN);
    endcase
  endfunction : cond
  // Bounded wait; n returns the cycles spent
  task automatic wait_for(input int s, input int lim);
    n = 0;
    while (!cond(s) && n < lim) begin @(posedge clk); n++; end
    if (n >= lim) begin num_errors++; $display("ERROR %0t: wait %0d", $time, s); wrap_up(); end
  endtask : wait_for
  task automatic t_regs();
    apb(0, OFS_CTRL, 0); chk(rd, 32'h0);
    apb(0, OFS_STATUS, 0); chk(rd, 32'h1);
    apb(0, 8'h10, 0); chk(err, 1'b1); chk(rd, 32'h0);
    $display("regs done");
  endtask : t_regs
  task automatic t_run();
    apb(1, OFS_CMD, 32'h1); wait_for(5, 1000); wait_for(0, 300);
    @(posedge clk); chk(mstate, ST_FETCH);
    chk(tres, 1'b1);
    // The compare edge already lies one past the pulse edge
    n = 1;
    do begin @(posedge clk); n++; end while (tick !== 1'b1 && n < 300);
    chk(n, {24'h0, CYC_BASE});
    sel_busy <= 1'b1; wait_for(5, 300); wait_for(0, 300); chk(tres, 1'b0);
    $display("run done");
  endtask : t_run
  task automatic t_stop_dch();
    apb(1, OFS_CMD, 32'h2); wait_for(1, 1000); chk(mstate, ST_FETCH);
    dch_req <= 1'b1; wait_for(2, 500); dch_req <= 1'b0;
    chk({dch_active, mstate}, {1'b1, ST_DCH});
    @(posedge clk); chk(ctl_n, 8'hFF ^ (8'h1 << C_BUS_HOLD) ^ (8'h1 << C_MEM_READ));
    chk(bhe, 1'b1);
    chk({bh, dr}, 2'b00);
    $display("stop and channel done");
  endtask : t_stop_dch
  // Write-back test word, skip pre-phase, slow memory, then interrupt entry
  task automatic t_mem();
    mref <= 1'b1; kind <= K_INCT; skip <= 1'b1; slow <= 1'b1;
    apb(1, OFS_CMD, 32'h1); wait_for(6, 1000);
    n = 1;
    do begin @(posedge clk); n++; end while (tick !== 1'b1 && n < 300);
    chk(n, {24'h0, CYC_SLOW});
    @(posedge clk); chk({phb, pha, mstate}, {PH_SKIP, ST_FETCH});
    apb(1, OFS_CTRL, 32'h1); int_req <= 1'b1; wait_for(7, 1000);
    int_req <= 1'b0; wait_for(8, 300); chk({phb, pha, mstate}, {PH_0, ST_DEFER});
    $display("memory and interrupt done");
  endtask : t_mem
  task automatic t_power();
    apb(1, OFS_CTRL, 32'h6); early_n <= 1'b0; mem_ok <= 1'b0;
    wait_for(4, 20); apb(1, OFS_CMD, 32'h1);
    apb(0, OFS_STATUS, 0); chk({rd[13:10]}, 4'hE);
    mem_ok <= 1'b1; early_n <= 1'b1; wait_for(3, 200);
    chk(n, RST_CYC + 1);
    @(posedge clk); @(posedge clk); chk(running, 1'b1);
    apb(1, OFS_CLEAR, 32'h1); apb(0, OFS_STATUS, 0); chk(rd[13], 1'b0);
    apb(1, OFS_CMD, 32'h4); chk(running, 1'b0);
    apb(1, OFS_CMD, 32'h8); wait_for(9, 200); chk(mstate, ST_KEY);
    $display("power done");
  endtask : t_power
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs(); t_run(); t_stop_dch(); t_mem(); t_power();
    wrap_up();
  end
endmodule : cpu_major_state_sequencer_tb
